/* hdl/peiu_pkg.sv */
// Purpose: shared constants and types of the phy event interrupt unit
// Assumes: 32-bit avalon-mm register port, byte addresses
// Notes: register indices are scaled by four to form byte addresses
package peiu_pkg;

    // register geometry
    localparam int REG_W = 16;
    localparam int EVT_W = 15;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // register indices and their byte addresses
    localparam logic [7:0] MASK_IDX = 8'h19;
    localparam logic [7:0] STAT_IDX = 8'h1a;
    localparam logic [ADDR_W-1:0] MASK_ADDR = {MASK_IDX[5:0], 2'h0};
    localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX[5:0], 2'h0};

    // reset values
    localparam logic [REG_W-1:0] MASK_RST = 16'h0000;
    localparam logic [REG_W-1:0] STAT_RST = 16'h0000;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    // field positions, shared by mask and status
    localparam int SUMMARY_BIT = 15;
    localparam int SPEED_BIT = 14;
    localparam int LINK_BIT = 13;
    localparam int DUPLEX_BIT = 12;
    localparam int ANEG_ERR_BIT = 11;
    localparam int ANEG_DONE_BIT = 10;
    localparam int PD_DETECT_BIT = 9;
    localparam int SYMBOL_ERR_BIT = 8;
    localparam int FAST_FAIL_BIT = 7;
    localparam int TX_FIFO_BIT = 6;
    localparam int RX_FIFO_BIT = 5;
    localparam int MEDIA_BIT = 4;
    localparam int FALSE_CARR_BIT = 3;
    localparam int DOWNSHIFT_BIT = 2;
    localparam int MS_ERR_BIT = 1;
    localparam int RX_ERR_BIT = 0;

    // all four advertisement bits must be set for downshift reporting
    localparam logic [3:0] DOWNSHIFT_ADV_ALL = 4'hf;

    // register bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h1,
        BUS_DONE = 2'h2
    } peiu_bus_state_t;

endpackage : peiu_pkg

/* hdl/peiu_event_gate.sv */
// Purpose: qualifies raw event pulses by their configuration conditions
// Assumes: all inputs come from logic on the same clock
// Notes: purely combinational, the caller registers the result
`timescale 1ns/1ps
module peiu_event_gate (
    // raw event pulses
    input wire logic [peiu_pkg::EVT_W-1:0] rawEvents,
    // qualifying conditions
    input wire logic autoNegEnable,
    input wire logic fastLinkFailEnable,
    input wire logic [3:0] downshiftAdvert,
    input wire logic rxErrCarrierExt,
    // qualified event pulses
    output logic [peiu_pkg::EVT_W-1:0] qualEvents
);

    // drop events whose enabling condition does not hold
    always_comb begin
        qualEvents = rawEvents;
        if (!autoNegEnable) begin
            qualEvents[peiu_pkg::SPEED_BIT] = 1'b0;
            qualEvents[peiu_pkg::DUPLEX_BIT] = 1'b0;
        end
        if (!fastLinkFailEnable) begin
            qualEvents[peiu_pkg::FAST_FAIL_BIT] = 1'b0;
        end
        if (downshiftAdvert != peiu_pkg::DOWNSHIFT_ADV_ALL) begin
            qualEvents[peiu_pkg::DOWNSHIFT_BIT] = 1'b0;
        end
        if (rxErrCarrierExt) begin
            qualEvents[peiu_pkg::RX_ERR_BIT] = 1'b0;
        end
    end

endmodule : peiu_event_gate

/* hdl/peiu_interrupt_unit.sv */
// Purpose: per-port event interrupt unit with mask, status and irq pin
// Assumes: one clock mclk at 125 MHz, synchronous active-low reset
// Notes: registers reached over avalon-mm with waitrequest
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module peiu_interrupt_unit (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // event pulses, one cycle each
    input wire logic speedChangeEvt,
    input wire logic linkChangeEvt,
    input wire logic duplexStateChangeEvt,
    input wire logic autoNegErrorEvt,
    input wire logic autoNegDoneEvt,
    input wire logic poweredDevDetectEvt,
    input wire logic symbolErrorEvt,
    input wire logic fastLinkFailEvt,
    input wire logic txFifoFaultEvt,
    input wire logic rxFifoFaultEvt,
    input wire logic autoMediaSelectChangeEvt,
    input wire logic falseCarrierEvt,
    input wire logic downshiftEvt,
    input wire logic masterSlaveErrorEvt,
    input wire logic rxErrorEvt,
    // qualifying levels from other control registers
    input wire logic autoNegEnable,
    input wire logic fastLinkFailEnable,
    input wire logic [3:0] downshiftAdvert,
    input wire logic rxErrCarrierExt,
    // avalon-mm register port
    input wire logic [peiu_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [peiu_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [peiu_pkg::BE_W-1:0] avs_byteenable,
    output logic [peiu_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // management interrupt, active high level
    output logic mgmtIrqPin
);

    // address decode used by read capture and write commit
    function automatic logic isMaskAddr(input logic [peiu_pkg::ADDR_W-1:0] addr);
        isMaskAddr = (addr == peiu_pkg::MASK_ADDR);
    endfunction : isMaskAddr

    function automatic logic isStatAddr(input logic [peiu_pkg::ADDR_W-1:0] addr);
        isStatAddr = (addr == peiu_pkg::STAT_ADDR);
    endfunction : isStatAddr

    // merge write data into a register under byte enables
    function automatic logic [peiu_pkg::REG_W-1:0] laneMerge(
        input logic [peiu_pkg::REG_W-1:0] oldVal,
        input logic [peiu_pkg::DATA_W-1:0] wdata,
        input logic [peiu_pkg::BE_W-1:0] be
    );
        logic [peiu_pkg::REG_W-1:0] merged;
        merged = oldVal;
        if (be[0]) begin
            merged[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            merged[15:8] = wdata[15:8];
        end
        laneMerge = merged;
    endfunction : laneMerge

    // state
    peiu_pkg::peiu_bus_state_t busState_reg;
    peiu_pkg::peiu_bus_state_t busState_next;
    logic [peiu_pkg::REG_W-1:0] eventEnableMask_reg;
    logic [peiu_pkg::REG_W-1:0] eventEnableMask_next;
    logic [peiu_pkg::REG_W-1:0] eventPendingFlags_reg;
    logic [peiu_pkg::REG_W-1:0] eventPendingFlags_next;
    logic [peiu_pkg::REG_W-1:0] readSnap_reg;
    logic [peiu_pkg::DATA_W-1:0] readData_reg;
    logic waitReq_reg;
    logic mgmtIrq_reg;

    // event path
    logic [peiu_pkg::EVT_W-1:0] rawEvents;
    logic [peiu_pkg::EVT_W-1:0] qualEvents;
    logic [peiu_pkg::EVT_W-1:0] enabledEvents;
    logic [peiu_pkg::REG_W-1:0] clearBits;

    // bus strobes
    logic busReq;
    logic busAccept;
    logic busCommit;
    logic statReadCommit;
    logic maskWriteCommit;

    // gather event pulses into their status positions
    always_comb begin
        rawEvents = '0;
        rawEvents[peiu_pkg::SPEED_BIT] = speedChangeEvt;
        rawEvents[peiu_pkg::LINK_BIT] = linkChangeEvt;
        rawEvents[peiu_pkg::DUPLEX_BIT] = duplexStateChangeEvt;
        rawEvents[peiu_pkg::ANEG_ERR_BIT] = autoNegErrorEvt;
        rawEvents[peiu_pkg::ANEG_DONE_BIT] = autoNegDoneEvt;
        rawEvents[peiu_pkg::PD_DETECT_BIT] = poweredDevDetectEvt;
        rawEvents[peiu_pkg::SYMBOL_ERR_BIT] = symbolErrorEvt;
        rawEvents[peiu_pkg::FAST_FAIL_BIT] = fastLinkFailEvt;
        rawEvents[peiu_pkg::TX_FIFO_BIT] = txFifoFaultEvt;
        rawEvents[peiu_pkg::RX_FIFO_BIT] = rxFifoFaultEvt;
        rawEvents[peiu_pkg::MEDIA_BIT] = autoMediaSelectChangeEvt;
        rawEvents[peiu_pkg::FALSE_CARR_BIT] = falseCarrierEvt;
        rawEvents[peiu_pkg::DOWNSHIFT_BIT] = downshiftEvt;
        rawEvents[peiu_pkg::MS_ERR_BIT] = masterSlaveErrorEvt;
        rawEvents[peiu_pkg::RX_ERR_BIT] = rxErrorEvt;
    end

    // per-source conditions applied before masking
    peiu_event_gate u_gate (
        .rawEvents(rawEvents),
        .autoNegEnable(autoNegEnable),
        .fastLinkFailEnable(fastLinkFailEnable),
        .downshiftAdvert(downshiftAdvert),
        .rxErrCarrierExt(rxErrCarrierExt),
        .qualEvents(qualEvents)
    );

    // only sources whose mask bit is one may latch
    assign enabledEvents = qualEvents & eventEnableMask_reg[peiu_pkg::EVT_W-1:0];

    // bus handshake strobes
    assign busReq = avs_read | avs_write;
    assign busAccept = (busState_reg == peiu_pkg::BUS_IDLE) && busReq;
    assign busCommit = (busState_reg == peiu_pkg::BUS_DONE) && busReq;
    assign statReadCommit = busCommit && avs_read && isStatAddr(avs_address);
    assign maskWriteCommit = busCommit && avs_write && isMaskAddr(avs_address);

    // clear exactly what the read returned, nothing that came later
    assign clearBits = statReadCommit ? readSnap_reg : '0;

    // bus state: accept, then complete one cycle later
    always_comb begin
        busState_next = busState_reg;
        unique case (busState_reg)
            peiu_pkg::BUS_IDLE: begin
                if (busReq) begin
                    busState_next = peiu_pkg::BUS_DONE;
                end
            end
            peiu_pkg::BUS_DONE: begin
                busState_next = peiu_pkg::BUS_IDLE;
            end
            default: begin
                busState_next = peiu_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            busState_reg <= peiu_pkg::BUS_IDLE;
        end else begin
            busState_reg <= busState_next;
        end
    end

    // waitrequest stays high except in the completing cycle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            waitReq_reg <= 1'b1;
        end else begin
            waitReq_reg <= ~busAccept;
        end
    end

    // mask register: plain sticky read/write, all bits
    always_comb begin
        eventEnableMask_next = eventEnableMask_reg;
        if (maskWriteCommit) begin
            eventEnableMask_next = laneMerge(eventEnableMask_reg, avs_writedata,
                avs_byteenable);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            eventEnableMask_reg <= peiu_pkg::MASK_RST;
        end else begin
            eventEnableMask_reg <= eventEnableMask_next;
        end
    end

    // status flags: set wins over the read clear, bus writes never land here
    always_comb begin
        eventPendingFlags_next = eventPendingFlags_reg & ~clearBits;
        eventPendingFlags_next[peiu_pkg::EVT_W-1:0] =
            eventPendingFlags_next[peiu_pkg::EVT_W-1:0] | enabledEvents;
        if (|enabledEvents) begin
            eventPendingFlags_next[peiu_pkg::SUMMARY_BIT] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            eventPendingFlags_reg <= peiu_pkg::STAT_RST;
        end else begin
            eventPendingFlags_reg <= eventPendingFlags_next;
        end
    end

    // snapshot of status taken when a status read is accepted
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            readSnap_reg <= peiu_pkg::STAT_RST;
        end else if (busAccept && avs_read && isStatAddr(avs_address)) begin
            readSnap_reg <= eventPendingFlags_reg;
        end
    end

    // read data captured at accept, stands through the completing cycle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            readData_reg <= peiu_pkg::RDATA_RST;
        end else if (busAccept && avs_read) begin
            if (isMaskAddr(avs_address)) begin
                readData_reg <= {16'h0000, eventEnableMask_reg};
            end else if (isStatAddr(avs_address)) begin
                readData_reg <= {16'h0000, eventPendingFlags_reg};
            end else begin
                readData_reg <= peiu_pkg::RDATA_RST; // unmapped reads zero
            end
        end
    end

    // pin follows the summary bit only while enabled
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mgmtIrq_reg <= 1'b0;
        end else begin
            mgmtIrq_reg <= eventEnableMask_next[peiu_pkg::SUMMARY_BIT] &
                eventPendingFlags_next[peiu_pkg::SUMMARY_BIT];
        end
    end

    // outputs straight from flip-flops
    assign avs_readdata = readData_reg;
    assign avs_waitrequest = waitReq_reg;
    assign mgmtIrqPin = mgmtIrq_reg;

endmodule : peiu_interrupt_unit

/* sim/peiu_props.sv */
// Purpose: port assertions for the event interrupt unit
// Assumes: one clock mclk, synchronous active-low resetn
// Notes: the mask is not visible here, so reads are tied to the pin
`timescale 1ns/1ps
module peiu_props (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port and pin
    input wire logic [peiu_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [peiu_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic mgmtIrqPin
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // completed transfers
    wire logic rdDone = avs_read && !avs_waitrequest;
    wire logic anyDone = (avs_read || avs_write) && !avs_waitrequest;
    wire logic statDone = rdDone && (avs_address == peiu_pkg::STAT_ADDR);
    // named properties
    property p_rst;
        disable iff (1'b0)
        !resetn |=> avs_waitrequest && !mgmtIrqPin && avs_readdata == 32'h0;
    endproperty
    property p_take;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    property p_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    property p_hi;
        rdDone |-> avs_readdata[31:16] == 16'h0;
    endproperty
    property p_sum;
        statDone |-> avs_readdata[15] == (avs_readdata[14:0] != 15'h0);
    endproperty
    property p_pinrd;
        statDone && !avs_readdata[15] |-> !$past(mgmtIrqPin);
    endproperty
    property p_fall;
        $fell(mgmtIrqPin) |-> $past(anyDone);
    endproperty
    property p_hold;
        avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata);
    endproperty
    a_rst: assert property (p_rst) else $error("port not reset");
    a_take: assert property (p_take) else $error("request not answered");
    a_one: assert property (p_one) else $error("waitrequest low too long");
    a_hi: assert property (p_hi) else $error("upper read bits set");
    a_sum: assert property (p_sum) else $error("summary bit mismatch");
    a_pinrd: assert property (p_pinrd) else $error("pin high without summary");
    a_fall: assert property (p_fall) else $error("pin fell without access");
    a_hold: assert property (p_hold) else $error("read data moved");
    // main scenarios reached
    c_pend: cover property (statDone && avs_readdata[15]);
    c_pin: cover property ($rose(mgmtIrqPin));
    c_wr: cover property (avs_write && !avs_waitrequest);
endmodule : peiu_props

bind peiu_interrupt_unit peiu_props peiu_props_inst (
    .mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mgmtIrqPin(mgmtIrqPin)
);

/* sim/peiu_host_model.sv */
// Purpose: host side model, an avalon-mm master for the register port
// Assumes: one clock mclk
// Notes: released address and write data lines show inverted values so stale data is never reused
`timescale 1ns/1ps
module peiu_host_model (
    // clock
    input wire logic mclk,
    // avalon-mm master
    output logic [peiu_pkg::ADDR_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [peiu_pkg::DATA_W-1:0] avs_writedata,
    output logic [peiu_pkg::BE_W-1:0] avs_byteenable,
    input wire logic avs_waitrequest
);
    // idle bus at time zero
    initial begin
        avs_address = 8'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
    end
    // one transfer, held until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~d;
    endtask : xfer
endmodule : peiu_host_model

/* sim/peiu_interrupt_unit_tb.sv */
// Purpose: self-checking bench for the event interrupt unit
// Assumes: host model drives the register port
// Notes: reads queue their expected word, a monitor compares
`timescale 1ns/1ps
module peiu_interrupt_unit_tb;
    localparam logic [7:0] MA = peiu_pkg::MASK_ADDR;
    localparam logic [7:0] SA = peiu_pkg::STAT_ADDR;
    logic mclk, resetn, autoNegEnable, fastLinkFailEnable, rxErrCarrierExt;
    logic [3:0] downshiftAdvert;
    logic [14:0] evt;
    logic [31:0] seed, m, e;
    logic [31:0] expQ[$];
    int nMismatch, totalChecks;
    wire logic [7:0] avs_address;
    wire logic [31:0] avs_writedata, avs_readdata;
    wire logic [3:0] avs_byteenable;
    wire logic avs_read, avs_write, avs_waitrequest, mgmtIrqPin;
    // design and host
    peiu_interrupt_unit peiu_interrupt_unit_inst (
        .mclk(mclk), .resetn(resetn), .speedChangeEvt(evt[14]), .linkChangeEvt(evt[13]),
        .duplexStateChangeEvt(evt[12]), .autoNegErrorEvt(evt[11]), .autoNegDoneEvt(evt[10]),
        .poweredDevDetectEvt(evt[9]), .symbolErrorEvt(evt[8]), .fastLinkFailEvt(evt[7]),
        .txFifoFaultEvt(evt[6]), .rxFifoFaultEvt(evt[5]), .autoMediaSelectChangeEvt(evt[4]),
        .falseCarrierEvt(evt[3]), .downshiftEvt(evt[2]), .masterSlaveErrorEvt(evt[1]),
        .rxErrorEvt(evt[0]), .autoNegEnable(autoNegEnable),
        .fastLinkFailEnable(fastLinkFailEnable), .downshiftAdvert(downshiftAdvert),
        .rxErrCarrierExt(rxErrCarrierExt), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .mgmtIrqPin(mgmtIrqPin));
    peiu_host_model host (
        .mclk(mclk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_waitrequest(avs_waitrequest));
    // xorshift source
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        totalChecks++;
        if (g !== x) begin
            nMismatch++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        expQ.push_back(x);
        host.xfer(1'b0, a, 32'h0, 4'hf);
    endtask : rd
    task automatic pulse(input logic [14:0] v);
        @(posedge mclk);
        evt <= v;
        @(posedge mclk);
        evt <= 15'h0;
    endtask : pulse
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // read monitor takes the oldest expectation
    always @(posedge mclk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (expQ.size() == 0) chk("queue", 32'h1, 32'h0);
            else chk("readdata", expQ.pop_front(), avs_readdata);
        end
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge mclk);
        nMismatch++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        {autoNegEnable, fastLinkFailEnable, rxErrCarrierExt} = 3'h6;
        downshiftAdvert = 4'hf;
        evt = 15'h0;
        resetn = 1'b0;
        seed = 32'h4c;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        rd(MA, 32'h0);
        rd(SA, 32'h0);
        rd(8'h00, 32'h0);
        host.xfer(1'b1, SA, 32'hffff, 4'hf);
        rd(SA, 32'h0);
        host.xfer(1'b1, MA, 32'h1234, 4'h2);
        rd(MA, 32'h1200);
        host.xfer(1'b1, MA, 32'h7fff, 4'hf);
        for (int i = 0; i < 15; i++) begin
            pulse(15'h1 << i);
            rd(SA, 32'h8000 | (32'h1 << i));
            chk("pin", 32'h0, {31'h0, mgmtIrqPin});
        end
        rd(SA, 32'h0);
        for (int i = 0; i < 8; i++) begin
            m = xs() & 32'h7fff;
            e = xs() & 32'h7fff;
            host.xfer(1'b1, MA, m, 4'hf);
            pulse(e[14:0]);
            rd(SA, ((e & m) != 0) ? (32'h8000 | (e & m)) : 32'h0);
        end
        host.xfer(1'b1, MA, 32'h7fff, 4'hf);
        {autoNegEnable, fastLinkFailEnable, rxErrCarrierExt} <= 3'h1;
        downshiftAdvert <= 4'h7;
        pulse(15'h7fff);
        rd(SA, 32'haf7a);
        {autoNegEnable, fastLinkFailEnable, rxErrCarrierExt} <= 3'h6;
        downshiftAdvert <= 4'hf;
        rd(SA, 32'h0);
        host.xfer(1'b1, MA, 32'ha000, 4'hf);
        rd(MA, 32'ha000);
        pulse(15'h2000);
        #1 chk("pin", 32'h1, {31'h0, mgmtIrqPin});
        host.xfer(1'b1, MA, 32'h2000, 4'hf);
        #1 chk("pin", 32'h0, {31'h0, mgmtIrqPin});
        pulse(15'h2000);
        rd(SA, 32'ha000);
        host.xfer(1'b1, MA, 32'ha000, 4'hf);
        fork
            rd(SA, 32'h0);
            pulse(15'h2000);
        join
        #1 chk("pin", 32'h1, {31'h0, mgmtIrqPin});
        rd(SA, 32'ha000);
        #1 chk("pin", 32'h0, {31'h0, mgmtIrqPin});
        pulse(15'h2000);
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        #1 chk("pin", 32'h0, {31'h0, mgmtIrqPin});
        rd(MA, 32'h0);
        rd(SA, 32'h0);
        tally_and_finish();
    end
endmodule : peiu_interrupt_unit_tb
